/* sideband_pkg.sv */
// Purpose: shared constants and types for the sideband clock/trip control
// Assumes: one bus clock domain (ref_clk); async pins synchronised on entry
// Notes:
// Notes on behaviour
// - on halt request, go to gated state and post a grant acknowledge on bus.
// - gated state stops core clocks; bus unit and interrupt unit keep running.
// - gated state services no interrupts; they stay pending until run resumes.
// - halt request removed: clocks back on for every unit, execution resumes.
// - halt request is asynchronous and never touches the bus clock.
// - accepted management interrupt saves state and enters protected handler mode.
// - then post management acknowledge on bus, then fetch handler code.
// - management interrupt held at reset release puts all outputs in high-Z.
// - raise overheat output when junction passes about 135 degrees C.
// - on overheat, stop internal clocks and halt all execution.
// - overheat output stays latched, device halted, until reset.
// - reset after a trip restarts the device at its boot vector.
// - still hot after reset: trip again and return to shutdown.
// - reset releases overheat output at once, even if still hot.
// - gated state entered twenty bus clocks after the acknowledge response.
// - gated state latches events; each serviced once after returning to run.
package sideband_pkg;

  // ******************************************************************
  // constants
  // ******************************************************************
  localparam int         SYNC_STAGES      = 3;
  localparam int         CNT_W            = 5;
  localparam logic [4:0] STOP_GRANT_DELAY = 5'h14;
  localparam logic [4:0] STRAP_SETTLE     = 5'h04;
  localparam logic [7:0] TRIP_CELSIUS     = 8'h87;
  localparam int         EVT_N            = 5;
  localparam int         EVT_MGMT         = 0;
  localparam int         EVT_INIT         = 1;
  localparam int         EVT_BUS_RECOVERY = 2;
  localparam int         EVT_IRQ0         = 3;
  localparam int         EVT_IRQ1         = 4;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic {ACK_STOP_GRANT, ACK_MGMT} ack_kind_t;

  typedef struct packed {
    logic      valid;
    ack_kind_t kind;
  } ack_req_t;

  typedef struct packed {
    logic ready;
    logic done;
  } ack_rsp_t;

  typedef struct packed {
    logic core;
    logic bus_unit;
    logic irq_unit;
  } clk_en_t;

  typedef enum logic [2:0] {
    ST_STRAP, ST_RUN, ST_SG_ACK, ST_SG_DELAY, ST_STOP_GRANT,
    ST_MGMT_SAVE, ST_MGMT_ACK, ST_SHUTDOWN
  } ctl_state_t;

endpackage

/* pin_sync.sv */
// Purpose: three-flop synchroniser for asynchronous pins
// Assumes: output level changes only once stages two and three agree
// Notes: stage one feeds stage two only
`timescale 1ns/1ps
module pin_sync #(
  parameter int   W       = 1,
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;

  sync_t q, d;

  always_comb
  begin
    d     = q;
    d.s1  = pin;
    d.s2  = q.s1;
    d.s3  = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
        d.lvl[i] = q.s3[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      q <= {4{{W{RST_VAL}}}};
    else
      q <= d;
  end

  assign level = q.lvl;

endmodule

/* event_latch.sv */
// Purpose: holds one occurrence of each event until it may be serviced
// Assumes: raise is a one-cycle pulse per event
// Notes: a new raise in the cycle of service is kept, not lost
`timescale 1ns/1ps
module event_latch #(
  parameter int N = 5
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] raise,
  input  wire logic         arm,
  input  wire logic         service_en,
  output logic      [N-1:0] pending,
  output logic      [N-1:0] fire
);

  typedef struct packed {
    logic [N-1:0] pend;
    logic [N-1:0] fire;
  } latch_t;

  latch_t q, d;

  always_comb
  begin
    d      = q;
    d.fire = q.pend & {N{service_en}};
    // set wins over the clear of a serviced bit
    d.pend = (q.pend & ~d.fire) | (raise & {N{arm}});
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign pending = q.pend;
  assign fire    = q.fire;

  AST_LATCH_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn)
    (arm && raise != '0) |=> ((pending & $past(raise)) == $past(raise)))
    else $error("raised event not held pending");

  // a raise in the cycle before a pulse legally brings a second pulse
  AST_FIRE_ONCE: assert property (@(posedge ref_clk) disable iff (!rstn)
    (fire != '0 && $past(raise) == '0) |=> ((fire & $past(fire)) == '0))
    else $error("event serviced twice");

endmodule

/* sideband_ctrl.sv */
// Purpose: stop-clock, management interrupt entry and overheat trip control
// Assumes: bus unit answers acknowledge requests with ready, then done
// Notes: die temperature comes from a sensor on the same clock
`timescale 1ns/1ps
module sideband_ctrl #(
  parameter logic [7:0] TRIP_C = sideband_pkg::TRIP_CELSIUS
) (
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  input  wire logic                           core_clock_halt_request_n,
  input  wire logic                           mgmt_interrupt_request_n,
  input  wire logic                           init_request_n,
  input  wire logic                           bus_recovery_request_n,
  input  wire logic [1:0]                     local_irq_lines,
  input  wire logic [7:0]                     die_temp_c,
  input  wire sideband_pkg::ack_rsp_t         ack_rsp,
  input  wire logic                           handler_exit,
  output sideband_pkg::ack_req_t              ack_req,
  output sideband_pkg::clk_en_t               clk_en,
  output logic                                protected_handler_mode,
  output logic                                state_save,
  output logic                                handler_fetch,
  output logic                                boot_fetch,
  output logic [sideband_pkg::EVT_N-1:0]      event_fire,
  output logic                                outputs_hiz,
  output logic                                overheat_shutdown_out
);

  // ******************************************************************
  // pin synchronisers and edge detect
  // ******************************************************************
  logic [5:0] pins_n;
  logic [5:0] lvl_n;
  logic       halt_lvl;
  logic       mgmt_lvl;
  logic [sideband_pkg::EVT_N-1:0] evt_lvl;
  logic [sideband_pkg::EVT_N-1:0] raise;
  logic [sideband_pkg::EVT_N-1:0] pending;
  logic       hot;

  assign pins_n = {core_clock_halt_request_n, ~local_irq_lines,
                   bus_recovery_request_n, init_request_n,
                   mgmt_interrupt_request_n};

  pin_sync #(
    .W       (6),
    .RST_VAL (1'b1)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin     (pins_n),
    .level   (lvl_n)
  );

  // asynchronous requests only reach the state machine synchronised
  assign halt_lvl = ~lvl_n[5];
  assign evt_lvl  = ~lvl_n[4:0];
  assign mgmt_lvl = evt_lvl[sideband_pkg::EVT_MGMT];
  assign hot      = die_temp_c >= TRIP_C;

  // ******************************************************************
  // control state
  // ******************************************************************
  typedef struct packed {
    sideband_pkg::ctl_state_t       st;
    logic [sideband_pkg::CNT_W-1:0] cnt;
    logic                           trip;
    logic                           handler;
    logic                           hiz;
    sideband_pkg::ack_req_t         ack;
    sideband_pkg::clk_en_t          clk;
    logic                           save;
    logic                           fetch;
    logic                           boot;
    logic [sideband_pkg::EVT_N-1:0] prev;
  } ctl_t;

  ctl_t q, d;
  logic service_en;
  logic arm;

  // hold further service while a management pulse leaves run, so none is lost
  assign service_en = q.st == sideband_pkg::ST_RUN && !event_fire[sideband_pkg::EVT_MGMT];
  assign arm        = q.st != sideband_pkg::ST_STRAP;
  assign raise      = evt_lvl & ~q.prev;

  event_latch #(
    .N (sideband_pkg::EVT_N)
  ) u_events (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .raise      (raise),
    .arm        (arm),
    .service_en (service_en),
    .pending    (pending),
    .fire       (event_fire)
  );

  always_comb
  begin
    d       = q;
    d.prev  = evt_lvl;
    d.save  = 1'b0;
    d.fetch = 1'b0;
    d.boot  = 1'b0;
    if (q.ack.valid && ack_rsp.ready)
      d.ack.valid = 1'b0;
    case (q.st)
      sideband_pkg::ST_STRAP:
      begin
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == sideband_pkg::STRAP_SETTLE)
        begin
          d.hiz  = mgmt_lvl;
          d.boot = 1'b1;
          d.cnt  = '0;
          d.st   = sideband_pkg::ST_RUN;
        end
      end
      sideband_pkg::ST_RUN:
      begin
        if (handler_exit)
          d.handler = 1'b0;
        if (event_fire[sideband_pkg::EVT_MGMT])
        begin
          d.save = 1'b1;
          d.st   = sideband_pkg::ST_MGMT_SAVE;
        end
        // a management event about to fire goes first, or its pulse would be lost
        else if (halt_lvl && !pending[sideband_pkg::EVT_MGMT])
        begin
          d.ack.valid = 1'b1;
          d.ack.kind  = sideband_pkg::ACK_STOP_GRANT;
          d.st        = sideband_pkg::ST_SG_ACK;
        end
      end
      sideband_pkg::ST_SG_ACK:
      begin
        if (ack_rsp.done)
        begin
          d.cnt = '0;
          d.st  = sideband_pkg::ST_SG_DELAY;
        end
      end
      sideband_pkg::ST_SG_DELAY:
      begin
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == sideband_pkg::STOP_GRANT_DELAY - 5'h01)
        begin
          d.cnt = '0;
          d.st  = sideband_pkg::ST_STOP_GRANT;
        end
      end
      sideband_pkg::ST_STOP_GRANT:
      begin
        // platform only drops the request once we sit here
        if (!halt_lvl)
          d.st = sideband_pkg::ST_RUN;
      end
      sideband_pkg::ST_MGMT_SAVE:
      begin
        d.handler   = 1'b1;
        d.ack.valid = 1'b1;
        d.ack.kind  = sideband_pkg::ACK_MGMT;
        d.st        = sideband_pkg::ST_MGMT_ACK;
      end
      sideband_pkg::ST_MGMT_ACK:
      begin
        if (ack_rsp.done)
        begin
          d.fetch = 1'b1;
          d.st    = sideband_pkg::ST_RUN;
        end
      end
      sideband_pkg::ST_SHUTDOWN:
      begin
        d.trip = 1'b1;
      end
      default:
      begin
        d.st = sideband_pkg::ST_SHUTDOWN;
      end
    endcase
    // overheat wins over everything and holds until reset
    if (hot || q.trip)
    begin
      d.trip      = 1'b1;
      d.st        = sideband_pkg::ST_SHUTDOWN;
      d.ack.valid = 1'b0;
      d.save      = 1'b0;
      d.fetch     = 1'b0;
      d.boot      = 1'b0;
    end
    // core gated while granted or shut down; bus and interrupt units stop only in shutdown
    d.clk.core     = !(d.st inside {sideband_pkg::ST_STOP_GRANT,
                                    sideband_pkg::ST_SHUTDOWN});
    d.clk.bus_unit = d.st != sideband_pkg::ST_SHUTDOWN;
    d.clk.irq_unit = d.st != sideband_pkg::ST_SHUTDOWN;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      q      <= '0;
      q.st   <= sideband_pkg::ST_STRAP;
      q.clk  <= 3'h7;
      q.prev <= '0;
    end
    else
      q <= d;
  end

  // ******************************************************************
  // outputs
  // ******************************************************************
  assign ack_req                = q.ack;
  assign clk_en                 = q.clk;
  assign protected_handler_mode = q.handler;
  assign state_save             = q.save;
  assign handler_fetch          = q.fetch;
  assign boot_fetch             = q.boot;
  assign outputs_hiz            = q.hiz;
  // gated by reset so the release does not wait for a clock edge
  assign overheat_shutdown_out  = q.trip & rstn;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_SG_DELAY: assert property (
    (q.st == sideband_pkg::ST_SG_ACK && ack_rsp.done && !hot)
    |-> ##21 (q.st == sideband_pkg::ST_STOP_GRANT || q.trip))
    else $error("gated state not entered twenty clocks after response");

  AST_SG_ACK: assert property (
    (q.st == sideband_pkg::ST_RUN && halt_lvl && !hot
     && !event_fire[sideband_pkg::EVT_MGMT] && !pending[sideband_pkg::EVT_MGMT])
    |=> (ack_req.valid && ack_req.kind == sideband_pkg::ACK_STOP_GRANT))
    else $error("no grant acknowledge after halt request");

  AST_GATED: assert property (
    q.st == sideband_pkg::ST_STOP_GRANT
    |-> (!clk_en.core && clk_en.bus_unit && clk_en.irq_unit))
    else $error("wrong clock enables in gated state");

  AST_RESUME: assert property (
    (q.st == sideband_pkg::ST_STOP_GRANT && !halt_lvl && !hot)
    |=> (clk_en.core && q.st == sideband_pkg::ST_RUN))
    else $error("clocks not restored after halt release");

  AST_BUS_ALIVE: assert property (
    !q.trip |-> clk_en.bus_unit)
    else $error("bus unit clock stopped outside shutdown");

  AST_MGMT_ENTRY: assert property (
    (q.st == sideband_pkg::ST_RUN && event_fire[sideband_pkg::EVT_MGMT] && !hot)
    |=> state_save ##1 (protected_handler_mode && ack_req.valid
                        && ack_req.kind == sideband_pkg::ACK_MGMT))
    else $error("management entry sequence wrong");

  AST_HANDLER_FETCH: assert property (
    (q.st == sideband_pkg::ST_MGMT_ACK && ack_rsp.done && !hot)
    |=> (handler_fetch && protected_handler_mode))
    else $error("handler fetch missing after acknowledge");

  AST_STRAP: assert property (
    (q.st == sideband_pkg::ST_STRAP && q.cnt == sideband_pkg::STRAP_SETTLE && !hot)
    |=> (outputs_hiz == $past(mgmt_lvl) && boot_fetch))
    else $error("strap or boot fetch wrong at reset release");

  AST_TRIP_SET: assert property (
    hot |=> overheat_shutdown_out)
    else $error("overheat output not raised");

  AST_TRIP_HOLD: assert property (
    q.trip |=> (q.trip && q.st == sideband_pkg::ST_SHUTDOWN && clk_en == '0))
    else $error("trip not latched with clocks off");

  AST_TRIP_RELEASE: assert property (@(posedge ref_clk) disable iff (1'b0)
    !rstn |-> !overheat_shutdown_out)
    else $error("overheat output held during reset");

endmodule

/* bus_unit_model.sv */
// Purpose: bus unit stand-in that answers acknowledge requests
// Assumes: a request stays up until ready is sampled high
// Notes: slow holds ready back three cycles; done rises three cycles after ready rises
`timescale 1ns/1ps
module bus_unit_model (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   slow,
  input  wire sideband_pkg::ack_req_t ack_req,
  output sideband_pkg::ack_rsp_t      ack_rsp
);
  // ****************************************************************
  // responder
  // ****************************************************************
  initial
  begin
    ack_rsp = 2'h0;
    forever
    begin
      @(posedge ref_clk);
      #1;
      if (rstn && ack_req.valid)
      begin
        repeat (slow ? 3 : 0)
        begin
          @(posedge ref_clk);
          #1;
        end
        ack_rsp.ready = 1'b1;
        @(posedge ref_clk);
        #1;
        ack_rsp.ready = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        ack_rsp.done = 1'b1;
        @(posedge ref_clk);
        #1;
        ack_rsp.done = 1'b0;
      end
    end
  end
endmodule

/* testbench.sv */
// Purpose: self-checking bench for the sideband clock, interrupt and trip control
// Assumes: inputs move 1 ns after the rising edge; outputs read there too
// Notes: the bus unit model answers every acknowledge request
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module testbench;
  logic                   ref_clk      = 1'b0;
  logic                   rstn         = 1'b0;
  logic                   halt_n       = 1'b1;
  logic                   mgmt_n       = 1'b1;
  logic                   init_n       = 1'b1;
  logic                   brec_n       = 1'b1;
  logic                   handler_exit = 1'b0;
  logic                   slow         = 1'b0;
  logic [1:0]             irq_lines    = 2'h0;
  logic [7:0]             temp         = 8'h19;
  sideband_pkg::ack_req_t ack_req;
  sideband_pkg::ack_rsp_t ack_rsp;
  sideband_pkg::clk_en_t  clk_en;
  logic                   phm;
  logic                   save;
  logic                   hfetch;
  logic                   bfetch;
  logic                   hiz;
  logic                   trip;
  logic [4:0]             fire;
  int                     fail_count   = 0;
  int                     compares     = 0;
  int                     cycles       = 0;
  int                     n;
  int                     k;
  int                     cnt[8];

  sideband_ctrl dut (
    .ref_clk                   (ref_clk),
    .rstn                      (rstn),
    .core_clock_halt_request_n (halt_n),
    .mgmt_interrupt_request_n  (mgmt_n),
    .init_request_n            (init_n),
    .bus_recovery_request_n    (brec_n),
    .local_irq_lines           (irq_lines),
    .die_temp_c                (temp),
    .ack_rsp                   (ack_rsp),
    .handler_exit              (handler_exit),
    .ack_req                   (ack_req),
    .clk_en                    (clk_en),
    .protected_handler_mode    (phm),
    .state_save                (save),
    .handler_fetch             (hfetch),
    .boot_fetch                (bfetch),
    .event_fire                (fire),
    .outputs_hiz               (hiz),
    .overheat_shutdown_out     (trip)
  );

  bus_unit_model bus_unit (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .slow    (slow),
    .ack_req (ack_req),
    .ack_rsp (ack_rsp)
  );

  // ****************************************************************
  // clock, watchdog and helpers
  // ****************************************************************
  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // advance c cycles, tallying event and handler pulses
  task step(input int c);
    repeat (c)
    begin
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 5; i++)
        cnt[i] += int'(fire[i]);
      cnt[5] += int'(save);
      cnt[6] += int'(hfetch);
      if (ack_req.valid === 1'b1 && ack_req.kind === sideband_pkg::ACK_MGMT)
        cnt[7] = 1;
    end
  endtask

  task reboot(input int hold);
    rstn = 1'b0;
    step(hold);
    rstn = 1'b1;
    n = 0;
    while (bfetch !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset_boot;
    step(9);
    `CHECK(trip, 1'b0)
    `CHECK(clk_en, 3'h7)
    `CHECK(ack_req.valid, 1'b0)
    reboot(1);
    `CHECK(bfetch, 1'b1)
    `CHECK(n <= 8, 1'b1)
    `CHECK(hiz, 1'b0)
  endtask

  task t_halt_events;
    slow = 1'b1;
    halt_n = 1'b0;
    n = 0;
    while (ack_req.valid !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    `CHECK(ack_req.kind, sideband_pkg::ACK_STOP_GRANT)
    `CHECK(n <= 6, 1'b1)
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (ack_rsp.done !== 1'b1 && n < 100);
    #1;
    k = 0;
    while (clk_en.core !== 1'b0 && k < 40)
    begin
      step(1);
      k++;
    end
    `CHECK(k, 20)
    `CHECK(clk_en, 3'h3)
    foreach (cnt[i])
      cnt[i] = 0;
    repeat (2)
    begin
      mgmt_n = 1'b0;
      init_n = 1'b0;
      brec_n = 1'b0;
      irq_lines = 2'h3;
      step(6);
      mgmt_n = 1'b1;
      init_n = 1'b1;
      brec_n = 1'b1;
      irq_lines = 2'h0;
      step(6);
    end
    `CHECK(cnt.sum(), 0)
    `CHECK(clk_en, 3'h3)
    slow = 1'b0;
    halt_n = 1'b1;
    n = 0;
    while (clk_en.core !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    `CHECK(clk_en, 3'h7)
    `CHECK(n <= 6, 1'b1)
    step(60);
    for (int i = 0; i < 5; i++)
      `CHECK(cnt[i], 1)
    `CHECK(cnt[5], 1)
    `CHECK(cnt[6], 1)
    `CHECK(cnt[7], 1)
    `CHECK(phm, 1'b1)
    handler_exit = 1'b1;
    step(1);
    handler_exit = 1'b0;
    step(3);
    `CHECK(phm, 1'b0)
  endtask

  task t_strap;
    rstn = 1'b0;
    mgmt_n = 1'b0;
    step(10);
    rstn = 1'b1;
    step(10);
    `CHECK(hiz, 1'b1)
    mgmt_n = 1'b1;
    reboot(10);
    `CHECK(hiz, 1'b0)
  endtask

  task t_trip;
    temp = sideband_pkg::TRIP_CELSIUS - 8'h01;
    step(3);
    `CHECK(trip, 1'b0)
    temp = sideband_pkg::TRIP_CELSIUS;
    step(1);
    `CHECK(trip, 1'b1)
    `CHECK(clk_en, 3'h0)
    temp = 8'h19; // platform cuts power on trip, so the die cools
    step(12);
    `CHECK(trip, 1'b1)
    `CHECK(clk_en, 3'h0)
    temp = 8'h8c;
    rstn = 1'b0;
    #1;
    `CHECK(trip, 1'b0)
    step(10);
    rstn = 1'b1;
    step(1);
    `CHECK(trip, 1'b1)
    temp = 8'h19;
    reboot(10);
    `CHECK(bfetch, 1'b1)
    `CHECK(trip, 1'b0)
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    t_reset_boot();
    t_halt_events();
    t_strap();
    t_trip();
    report_and_stop();
  end
endmodule
